// ---- sdf_decimation_filter.sv ----
// Four channel decimation filter with fast start path and register port
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Modulator bit every two main clocks
// - Single bit stream is sole filter input
// - Three bit select, ratios 128 to 16384
// - One word per ratio count of bits
// - Sinc3 and fast sinc1 paths in parallel
// - Fast path feeds results after reset
// - Sinc3 after two conversions until reset
// - Ratios up to 1024 use sinc3 directly
// - Larger ratios: sinc3 at 1024 plus sinc1
// - Nulls at data rate multiples, repeat at modulator
// - Settling time table per ratio setting
// - Results keep flowing while settling
// - Main clock divided by one, two, four
// - Sinc3 is normalised cubed moving sum
// - Results are 24 bit two's complement
module sdf_decimation_filter (
  // Clock and reset
  input  wire logic                               clock,
  input  wire logic                               rstn,
  // Register port
  input  wire sdf_pkg::sdf_bus_s                  bus,
  output logic [sdf_pkg::BusW-1:0]                rdData,
  // Modulator streams, one bit per channel
  input  wire logic [sdf_pkg::NumChan-1:0]        modBits,
  output logic                                    modulatorTick,
  // Configuration events from the front end
  input  wire logic                               resync,
  input  wire logic [sdf_pkg::NumChan-1:0]        muxGainChange,
  // Results
  output sdf_pkg::sdf_result_s                    result,
  output logic                                    sampleReadyStrobe,
  output logic [sdf_pkg::NumChan-1:0]             settlingActive
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [sdf_pkg::BusW-1:0] control_q;  // Software configuration
  logic [sdf_pkg::BusW-1:0] rdData_q;   // Read data, one cycle after strobe

  wire ctrlWrite   = bus.wrStrobe && (bus.addr == sdf_pkg::RegControl);
  wire settleWrite = bus.wrStrobe && (bus.addr == sdf_pkg::RegSettle);

  // Configuration fields
  wire [2:0]                  oversamplingRatioSelect = control_q[sdf_pkg::CtrlOsrLsb +: 3];
  wire [1:0]                  powerModeBits           = control_q[sdf_pkg::CtrlPwrLsb +: 2];
  wire [sdf_pkg::NumChan-1:0] chanEnable              = control_q[sdf_pkg::CtrlChenLsb +: 4];

  // Software resync shares the restart path with the pin
  wire swResync   = settleWrite && bus.wrData[sdf_pkg::SettleResyncBit];
  // A ratio or mode change leaves filter history meaningless, so restart too
  wire restartAll = resync | swResync | ctrlWrite;

  // Control register holds its value between writes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      control_q <= sdf_pkg::ControlReset;
    else if (ctrlWrite)
      control_q <= bus.wrData;
  end

  // ----------------------------------------------------------------
  // Main clock and modulator rate enables
  // ----------------------------------------------------------------
  logic [1:0] mainCnt_q;   // Divider for the power mode
  logic       modPhase_q;  // Second main tick marks a modulator bit

  sdf_pkg::sdf_power_e powerMode;
  assign powerMode = sdf_pkg::sdf_power_e'(powerModeBits);

  // Power mode picks the main clock divisor; a reserved code runs at full rate
  logic [1:0] mainDivLast;
  always_comb begin
    unique case (powerMode)
      sdf_pkg::HIGH_RESOLUTION_MODE: mainDivLast = sdf_pkg::MainDivHighRes;
      sdf_pkg::LOW_POWER_MODE:       mainDivLast = sdf_pkg::MainDivLowPwr;
      sdf_pkg::VERY_LOW_POWER_MODE:  mainDivLast = sdf_pkg::MainDivVeryLow;
      default:                       mainDivLast = sdf_pkg::MainDivHighRes;
    endcase
  end

  wire mainTick = (mainCnt_q >= mainDivLast);
  wire modTick  = mainTick & modPhase_q;

  // Divider chain; a mode write mid count is safe since the compare is >=
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mainCnt_q  <= '0;
      modPhase_q <= 1'b0;
    end else begin
      mainCnt_q <= mainTick ? 2'h0 : mainCnt_q + 2'h1;
      if (mainTick)
        modPhase_q <= ~modPhase_q;
    end
  end

  assign modulatorTick = modTick;

  // ----------------------------------------------------------------
  // Decimation timing shared by all channels
  // ----------------------------------------------------------------
  // Ratio as a power of two, and its split between the two stages
  wire [3:0] osrLog2   = sdf_pkg::OsrLog2Base + 4'(oversamplingRatioSelect);
  wire       bigRatio  = osrLog2 > sdf_pkg::Sinc3Log2Cap;
  wire [3:0] sinc3Log2 = bigRatio ? sdf_pkg::Sinc3Log2Cap : osrLog2;
  wire [3:0] postLog2  = osrLog2 - sinc3Log2;

  logic [13:0] modCnt_q;      // Modulator bits in the current output period
  logic        overallDly_q;  // Output period ended last cycle
  logic [1:0]  convCnt_q;     // Conversions since reset, stops at two

  wire [13:0] osrMask   = 14'((15'h0001 << osrLog2) - 15'h0001);
  wire [13:0] sinc3Mask = 14'((15'h0001 << sinc3Log2) - 15'h0001);
  // Sinc3 decimates at its own ratio, the output period at the overall one
  wire decimTick   = modTick && ((modCnt_q & sinc3Mask) == sinc3Mask);
  wire overallTick = modTick && (modCnt_q == osrMask);
  // Fast path serves the first two conversions only
  wire fastPath    = convCnt_q < sdf_pkg::FastConvCount;

  // Period counter restarts on any resynchronisation
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      modCnt_q     <= '0;
      overallDly_q <= 1'b0;
    end else if (restartAll) begin
      modCnt_q     <= '0;
      overallDly_q <= 1'b0;
    end else begin
      overallDly_q <= overallTick;
      if (modTick)
        modCnt_q <= overallTick ? 14'h0000 : modCnt_q + 14'h0001;
    end
  end

  // Path choice only returns to the fast path on a device reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      convCnt_q <= '0;
    else if (overallDly_q && fastPath)
      convCnt_q <= convCnt_q + 2'h1;
  end

  // One shared ready strobe, registered beside the words
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      sampleReadyStrobe <= 1'b0;
    else
      sampleReadyStrobe <= overallDly_q;
  end

  // Path flag of the words now on the output
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      result.fastPath <= 1'b1;
    else if (overallDly_q)
      result.fastPath <= fastPath;
  end

  // ----------------------------------------------------------------
  // Per channel filters
  // ----------------------------------------------------------------
  wire [15:0] settleLoad = sdf_pkg::SettlePeriods[oversamplingRatioSelect];
  logic [sdf_pkg::NumChan-1:0] chanEnable_q;  // Previous enables, for rising edges
  logic [sdf_pkg::NumChan-1:0][sdf_pkg::DataW-1:0] chanWord;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      chanEnable_q <= '0;
    else
      chanEnable_q <= chanEnable;
  end

  for (genvar c = 0; c < sdf_pkg::NumChan; c++) begin : gChan
    logic signed [sdf_pkg::FastW-1:0] fastAcc_q;   // Fast sinc1 running sum
    logic signed [sdf_pkg::DataW-1:0] fastWord_q;  // Fast result of last period
    logic signed [sdf_pkg::PostW-1:0] postAcc_q;   // Post stage running sum
    logic signed [sdf_pkg::DataW-1:0] outWord_q;   // Word on the output
    logic        [15:0]               settle_q;    // Modulator periods left
    logic signed [sdf_pkg::DataW-1:0] s3Word;
    logic                             s3Valid;

    // A disabled channel is held in restart and reads as zero
    wire chanRestart = restartAll | ~chanEnable[c];

    // The bit stream is the only data entering the filters
    wire modBit = modBits[c];

    sdf_sinc3_channel uSinc3 (
      .clock     (clock),
      .rstn      (rstn),
      .modTick   (modTick),
      .modBit    (modBit),
      .decimTick (decimTick),
      .restart   (chanRestart),
      .log2N     (sinc3Log2),
      .word      (s3Word),
      .valid     (s3Valid)
    );

    // Fast path: plain moving sum over the overall ratio, scaled to full scale
    wire signed [sdf_pkg::FastW-1:0] fastStep = modBit ? 16'sh0001 : -16'sh0001;
    wire signed [sdf_pkg::FastW-1:0] fastNext = fastAcc_q + fastStep;
    wire        [4:0]                fastShl  = sdf_pkg::FastShiftTop - 5'(osrLog2);
    wire signed [sdf_pkg::DataW:0]   fastExt  = 25'(fastNext) <<< fastShl;
    wire fastOver = fastExt > 25'(sdf_pkg::FullPos);

    // Fast sum runs beside the sinc3 path at all times
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        fastAcc_q  <= '0;
        fastWord_q <= '0;
      end else if (chanRestart) begin
        fastAcc_q  <= '0;
      end else if (modTick) begin
        fastAcc_q <= overallTick ? 16'sh0000 : fastNext;
        if (overallTick)
          fastWord_q <= fastOver ? sdf_pkg::FullPos : fastExt[sdf_pkg::DataW-1:0];
      end
    end

    // Post stage: average of the sinc3 words in one output period
    wire signed [sdf_pkg::PostW-1:0] postSum = postAcc_q + 28'(s3Word);
    wire signed [sdf_pkg::PostW-1:0] postAvg = postSum >>> postLog2;

    // The last sinc3 word of a period arrives with the delayed period tick
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
        postAcc_q <= '0;
      else if (chanRestart)
        postAcc_q <= '0;
      else if (s3Valid)
        postAcc_q <= overallDly_q ? 28'sh000_0000 : postSum;
    end

    // Output word: both paths aligned to the same period end
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
        outWord_q <= '0;
      else if (overallDly_q) begin
        if (!chanEnable[c])
          outWord_q <= '0;
        else if (fastPath)
          outWord_q <= fastWord_q;
        else
          outWord_q <= postAvg[sdf_pkg::DataW-1:0];
      end
    end

    // Settling timer: restarted by enable, mux or gain change, resync
    wire settleStart = (chanEnable[c] & ~chanEnable_q[c]) | muxGainChange[c]
                     | restartAll | (settleWrite & bus.wrData[c]);

    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
        settle_q <= '0;
      else if (settleStart)
        settle_q <= settleLoad;
      else if (modTick && (settle_q != 16'h0000))
        settle_q <= settle_q - 16'h0001;
    end

    // Flag is status only; words are never held back or tagged
    assign settlingActive[c] = (settle_q != 16'h0000);
    assign chanWord[c]       = outWord_q;
    assign result.word[c]    = outWord_q;
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  wire        isData   = (bus.addr >= sdf_pkg::RegData0);
  wire [1:0]  dataSel  = 2'(bus.addr - sdf_pkg::RegData0);
  wire [31:0] statWord = {22'h00_0000, convCnt_q, 3'h0, fastPath, settlingActive};
  wire [31:0] dataWord = {{8{chanWord[dataSel][sdf_pkg::DataW-1]}}, chanWord[dataSel]};

  // Address 3 and the write-only settle register read as zero; addresses above 7 repeat the data words
  logic [31:0] rdMux;
  always_comb begin
    if (bus.addr == sdf_pkg::RegControl)
      rdMux = control_q;
    else if (bus.addr == sdf_pkg::RegStatus)
      rdMux = statWord;
    else if (isData)
      rdMux = dataWord;
    else
      rdMux = '0;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      rdData_q <= '0;
    else
      rdData_q <= bus.rdStrobe ? rdMux : 32'h0000_0000;
  end

  assign rdData = rdData_q;

endmodule

`default_nettype wire

// ---- sdf_pkg.sv ----
// Shared constants, types and tables for the decimation filter block
package sdf_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NumChan = 4;   // Converter channels
  localparam int DataW   = 24;  // Result word width
  localparam int CicW    = 32;  // Sinc3 integrator width, 3*10 bits growth plus sign
  localparam int FastW   = 16;  // Fast path accumulator, +-16384 plus sign
  localparam int PostW   = 28;  // Post stage accumulator, 16 words of 24 bits
  localparam int AddrW   = 4;   // Register address width
  localparam int BusW    = 32;  // Register data width

  // ----------------------------------------------------------------
  // Clock rates and ratios
  // ----------------------------------------------------------------
  localparam logic [1:0] MainDivHighRes = 2'h0;  // Main clock at full rate, count minus one
  localparam logic [1:0] MainDivLowPwr  = 2'h1;  // Main clock halved
  localparam logic [1:0] MainDivVeryLow = 2'h3;  // Main clock quartered
  localparam logic [3:0] OsrLog2Base    = 4'h7;  // Smallest ratio is 2**7 = 128
  localparam logic [3:0] Sinc3Log2Cap   = 4'hA;  // Sinc3 ratio stops at 2**10 = 1024
  localparam logic [5:0] Sinc3ShiftBias = 6'h15; // 3*7 bits of growth at ratio 128
  localparam logic [4:0] FastShiftTop   = 5'h17; // Full scale bit position of a result
  localparam logic [1:0] FastConvCount  = 2'h2;  // Conversions taken from the fast path

  // Settling time in modulator periods, indexed by ratio select
  localparam logic [15:0] SettlePeriods [8] = '{
    16'h01B0, 16'h0330, 16'h0630, 16'h0C30,
    16'h1830, 16'h2830, 16'h4830, 16'h8830
  };

  localparam logic signed [DataW-1:0] FullPos = 24'h7F_FFFF; // Positive clamp value

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [AddrW-1:0] RegControl = 4'h0;  // Ratio, power mode, channel enables
  localparam logic [AddrW-1:0] RegStatus  = 4'h1;  // Conversion count, path, settling
  localparam logic [AddrW-1:0] RegSettle  = 4'h2;  // Write ones to restart settling timers
  localparam logic [AddrW-1:0] RegData0   = 4'h4;  // Channel 0 result, channels follow

  localparam int CtrlOsrLsb  = 0;  // Ratio select, 3 bits
  localparam int CtrlPwrLsb  = 4;  // Power mode, 2 bits
  localparam int CtrlChenLsb = 8;  // Channel enables, 4 bits
  localparam int StatSetLsb  = 0;  // Settling flags, 4 bits
  localparam int StatFastBit = 4;  // Fast path in use
  localparam int StatConvLsb = 8;  // Conversion count, 2 bits
  localparam int SettleResyncBit = 4; // Resynchronise all channels

  localparam logic [BusW-1:0] ControlReset = 32'h0000_0F00; // Ratio 128, full rate, all on

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HIGH_RESOLUTION_MODE,
    LOW_POWER_MODE,
    VERY_LOW_POWER_MODE
  } sdf_power_e;

  typedef struct packed {
    logic             wrStrobe;
    logic             rdStrobe;
    logic [AddrW-1:0] addr;
    logic [BusW-1:0]  wrData;
  } sdf_bus_s;

  typedef struct packed {
    logic                            fastPath;
    logic [NumChan-1:0][DataW-1:0]   word;
  } sdf_result_s;

endpackage

// ---- sdf_sinc3_channel.sv ----
// Third order sinc decimator for one modulator bit stream
`timescale 1ns/100ps
`default_nettype none

module sdf_sinc3_channel (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rstn,
  // Stream and timing
  input  wire logic                          modTick,
  input  wire logic                          modBit,
  input  wire logic                          decimTick,
  input  wire logic                          restart,
  input  wire logic [3:0]                    log2N,
  // Result
  output logic signed [sdf_pkg::DataW-1:0]   word,
  output logic                               valid
);

  // ----------------------------------------------------------------
  // Integrators and comb delays
  // ----------------------------------------------------------------
  localparam int W = sdf_pkg::CicW;

  logic signed [W-1:0] int1_q, int2_q, int3_q;   // Integrator chain
  logic signed [W-1:0] dly1_q, dly2_q, dly3_q;   // Comb delay line
  wire  signed [W-1:0] inVal  = modBit ? W'(1) : -W'(1); // Ones density to +-1
  wire  signed [W-1:0] comb1  = int3_q - dly1_q;
  wire  signed [W-1:0] comb2  = comb1 - dly2_q;
  wire  signed [W-1:0] comb3  = comb2 - dly3_q;

  // Normalise by N cubed: bring 2**(3*log2N) down to 2**23
  wire        [5:0]    shiftR = 6'(6'(log2N) * 6'h03) - sdf_pkg::Sinc3ShiftBias;
  wire  signed [W+1:0] scaled = $signed({comb3, 2'b00}) >>> shiftR;
  // Only an exact positive full scale can overflow the word
  wire                 overPos = scaled > (W+2)'(sdf_pkg::FullPos);

  // ----------------------------------------------------------------
  // Filter state; wraparound in the integrators is harmless
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {int1_q, int2_q, int3_q} <= '0;
      {dly1_q, dly2_q, dly3_q} <= '0;
    end else if (restart) begin
      {int1_q, int2_q, int3_q} <= '0;
      {dly1_q, dly2_q, dly3_q} <= '0;
    end else if (modTick) begin
      int1_q <= int1_q + inVal;
      int2_q <= int2_q + int1_q;
      int3_q <= int3_q + int2_q;
      if (decimTick) begin
        dly1_q <= int3_q;
        dly2_q <= comb1;
        dly3_q <= comb2;
      end
    end
  end

  // Output word, registered once per decimation period
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      word  <= '0;
      valid <= 1'b0;
    end else begin
      valid <= modTick & decimTick & ~restart;
      if (modTick & decimTick)
        word <= overPos ? sdf_pkg::FullPos : scaled[sdf_pkg::DataW-1:0];
    end
  end

endmodule

`default_nettype wire

// ---- sdf_stream_model.sv ----
// Modulator bit stream source standing in front of the filter
`timescale 1ns/100ps
`default_nettype none

module sdf_stream_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Control from the bench
  input  wire logic [1:0] mode,
  input  wire logic [3:0] rndBits,
  // Stream
  input  wire logic       modulatorTick,
  output logic      [3:0] modBits
);
  // -------------------------------------------------------
  // Stream update
  // -------------------------------------------------------
  // New bit after each sampled tick, so the sample is never racing
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      modBits <= 4'h0;
    end else if (modulatorTick) begin
      modBits <= (mode == 2'h0) ? 4'hF : (mode == 2'h1) ? 4'h0 : rndBits;
    end
  end
endmodule
`default_nettype wire

// ---- sdf_decimation_filter_sva.sv ----
// Port level checker for the decimation filter
`timescale 1ns/100ps
`default_nettype none

module sdf_decimation_filter_sva (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rstn,
  // Watched ports
  input  wire sdf_pkg::sdf_bus_s             bus,
  input  wire logic [sdf_pkg::BusW-1:0]      rdData,
  input  wire logic [sdf_pkg::NumChan-1:0]   modBits,
  input  wire logic                          modulatorTick,
  input  wire logic                          resync,
  input  wire logic [sdf_pkg::NumChan-1:0]   muxGainChange,
  input  wire sdf_pkg::sdf_result_s          result,
  input  wire logic                          sampleReadyStrobe,
  input  wire logic [sdf_pkg::NumChan-1:0]   settlingActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  tick_gap_a: assert property (modulatorTick |=> !modulatorTick) else $error("tick too close");
  strobe_pulse_a: assert property (sampleReadyStrobe |=> !sampleReadyStrobe) else $error("long strobe");
  strobe_tick_a: assert property (sampleReadyStrobe |-> $past(modulatorTick, 2)) else $error("strobe late");
  words_hold_a: assert property (!sampleReadyStrobe |-> $stable(result.word)) else $error("word moved");
  path_keep_a: assert property (!result.fastPath |=> !result.fastPath) else $error("back to fast");
  path_change_a: assert property ($fell(result.fastPath) |-> sampleReadyStrobe) else $error("path switch");
  rd_idle_a: assert property (!$past(bus.rdStrobe) |-> rdData == '0) else $error("idle read data");
  rd_data_a: assert property ($past(bus.rdStrobe) && $past(bus.addr) == sdf_pkg::RegData0
    |-> rdData == {{8{$past(result.word[0][23])}}, $past(result.word[0])}) else $error("data read");
  settle_start_a: assert property (muxGainChange[2] |-> ##[1:3] settlingActive[2]) else $error("no settle");
endmodule

bind sdf_decimation_filter sdf_decimation_filter_sva chk (.clock(clock), .rstn(rstn), .bus(bus),
  .rdData(rdData), .modBits(modBits), .modulatorTick(modulatorTick), .resync(resync),
  .muxGainChange(muxGainChange), .result(result), .sampleReadyStrobe(sampleReadyStrobe),
  .settlingActive(settlingActive));
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the decimation filter
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  sdf_pkg::sdf_bus_s bus = '0;
  logic [31:0] rdData;
  logic [3:0] modBits, muxGainChange = 4'h0;
  logic modulatorTick, resync = 1'b0, sampleReadyStrobe;
  logic [3:0] settlingActive;
  sdf_pkg::sdf_result_s result;
  logic [1:0] mode = 2'h2;     // Stream kind: ones, zeros, random
  logic [15:0] lfsr = 16'h0037;
  int ones [4];                // Ones seen per channel this period
  int tks;                     // Ticks seen this period
  int miscompares = 0, num_checks = 0, cyc = 0, n;
  // -------------------------------------------------------
  // Clock, random source, period tally and watchdog
  // -------------------------------------------------------
  always #2.5 clock = ~clock;
  function automatic logic [15:0] lfsrNext(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Tally restarts on the strobe edge; that edge's tick opens the next period
  always @(posedge clock or negedge rstn) begin
    lfsr <= lfsrNext(lfsr);
    if (!rstn) begin
      tks <= 0;
      for (int c = 0; c < 4; c++) ones[c] <= 0;
    end else begin
      tks <= (sampleReadyStrobe ? 0 : tks) + int'(modulatorTick);
      for (int c = 0; c < 4; c++) ones[c] <= (sampleReadyStrobe ? 0 : ones[c])
        + int'(modulatorTick & modBits[c]);
    end
    cyc++;
    // Ceiling sits about twice above the longest expected run
    if (cyc > 80000) begin
      miscompares++;
      finish_test();
    end
  end
  sdf_stream_model model (.clock(clock), .rstn(rstn), .mode(mode), .rndBits(lfsr[3:0]),
    .modulatorTick(modulatorTick), .modBits(modBits));
  sdf_decimation_filter dut (.clock(clock), .rstn(rstn), .bus(bus), .rdData(rdData),
    .modBits(modBits), .modulatorTick(modulatorTick), .resync(resync),
    .muxGainChange(muxGainChange), .result(result), .sampleReadyStrobe(sampleReadyStrobe),
    .settlingActive(settlingActive));
  // -------------------------------------------------------
  // Helpers
  // -------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Fast path word: scaled ones minus zeros, positive end clamped
  function automatic logic [23:0] fastExp(int k, int l);
    int v = (2 * k - (1 << l)) * (1 << (23 - l));
    return (v > 8388607) ? 24'h7F_FFFF : v[23:0];
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{wrStrobe: 1'b1, rdStrobe: 1'b0, addr: a, wrData: d};
    @(posedge clock);
    bus.wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock);
    bus <= '{wrStrobe: 1'b0, rdStrobe: 1'b1, addr: a, wrData: 32'h0000_0000};
    @(posedge clock);
    bus.rdStrobe <= 1'b0;
    #1 chk(rdData & m, e, "read");
  endtask
  // Returns settled, one ns after the strobe edge; n counts cycles waited
  task automatic waitStrobe();
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (!sampleReadyStrobe && n < 40000);
    // A strobe that never comes is a failure, not a silent return
    if (!sampleReadyStrobe) begin
      miscompares++;
      $display("BAD %0t no ready strobe", $time);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Reset, then two fast words of random stream, then sinc3
  task automatic startCheck();
    rstn <= 1'b0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      waitStrobe();
      chk(result.fastPath, s < 2, "path");
      chk(tks, 128, "ticks per word");
      for (int c = 0; c < 4; c++)
        if (s < 2) chk(result.word[c], fastExp(ones[c], 7), "fast word");
    end
    $display("start test done");
  endtask
  // -------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------
  initial begin
    startCheck();
    rd(sdf_pkg::RegStatus, 32'h0000_0310, 32'h0000_0200);
    rd(4'h3, 32'hFFFF_FFFF, 32'h0000_0000);
    // Full scale both ways, read back sign extended
    for (int m = 0; m < 2; m++) begin
      mode <= 2'(m);
      repeat (4) waitStrobe();
      for (int c = 0; c < 4; c++) chk(result.word[c], m ? 24'h80_0000 : 24'h7F_FFFF, "sinc3");
      rd(4'h5, 32'hFFFF_FFFF, m ? 32'hFF80_0000 : 32'h007F_FFFF);
    end
    resync <= 1'b1;
    @(posedge clock);
    resync <= 1'b0;
    waitStrobe();
    chk(result.fastPath, 1'b0, "resync path");
    $display("path test done");
    // Settle timer length at ratio 128, data still flowing
    mode <= 2'h2;
    wr(sdf_pkg::RegSettle, 32'h0000_0001);
    muxGainChange <= 4'h4;
    @(posedge clock);
    muxGainChange <= 4'h0;
    n = 0;
    // Flag is first read in the edge's own time step, then one ns past each later edge
    while (settlingActive[0] === 1'b1 && n < 2000) begin
      @(posedge clock);
      #1 n++;
    end
    chk(n >= 858 && n <= 866, 1'b1, "settle length");
    // Host keeps only the first word after the timer has run out
    waitStrobe();
    chk(settlingActive[0], 1'b0, "settled word");
    $display("settle test done");
    // Ratio and power mode sweeps: word spacing in clocks
    // Mode changes go only through a control write, which halts and restarts the filters
    for (int r = 0; r < 9; r++) begin
      wr(sdf_pkg::RegControl, r < 6 ? 32'h0000_0F00 | r : 32'h0000_0F00 | ((r - 5) << 4));
      waitStrobe();
      waitStrobe();
      chk(n, r < 6 ? 2 << (7 + r) : (r == 6 ? 512 : r == 7 ? 1024 : 256), "spacing");
      chk(tks, r < 6 ? 1 << (7 + r) : 128, "ticks");
    end
    $display("ratio test done");
    startCheck();
    finish_test();
  end
endmodule
`default_nettype wire
